// >>> rtl/amd_map.svh
// Constants for the address-mode decode block: field positions and mode codes.
`ifndef AMD_MAP_SVH
`define AMD_MAP_SVH

// Indexed postbyte field positions
`define AMD_POST_EXT_BIT 7
`define AMD_POST_IND_BIT 4

// Indexed mode codes in postbyte bits 3..0 (bit 7 set)
`define AMD_MODE_INC1 4'h0
`define AMD_MODE_INC2 4'h1
`define AMD_MODE_DEC1 4'h2
`define AMD_MODE_DEC2 4'h3
`define AMD_MODE_ZERO 4'h4
`define AMD_MODE_ACCB 4'h5
`define AMD_MODE_ACCA 4'h6
`define AMD_MODE_OFF8 4'h8
`define AMD_MODE_OFF16 4'h9
`define AMD_MODE_ACCD 4'hb
`define AMD_MODE_PC8 4'hc
`define AMD_MODE_PC16 4'hd
`define AMD_MODE_EXTIND 4'hf

// Register codes of the copy and swap postbyte
`define AMD_REG_D 4'h0
`define AMD_REG_PC 4'h5
`define AMD_REG_A 4'h8
`define AMD_REG_DPR 4'hb

// Reset value and last stack-walk step
`define AMD_RST_WORD 16'h0000
`define AMD_STK_LAST 3'h7

`endif

// >>> rtl/amd_pkg.sv
// Types shared by the address-mode decode block.
package amd_pkg;
	// Kind of request presented at i_start
	typedef enum logic [1:0] {
		KIND_INDEXED,
		KIND_BRANCH,
		KIND_STACK,
		KIND_XFER
	} amd_kind_type;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_IND_HI,
		ST_IND_LO,
		ST_STK
	} amd_state_type;
endpackage

// >>> rtl/amd_decode.sv
// Operand effective-address and postbyte decode unit.
//
// Summary of operation
// RULE1: Constant-offset indexed adds signed offset to pointer; pointer itself is not changed.
// RULE2: Constant offsets come in 5-bit, 8-bit and 16-bit signed widths.
// RULE3: A 5-bit offset sits inside the postbyte; no extra bytes fetched.
// RULE4: 8-bit offset is one byte after postbyte; 16-bit offset is two bytes.
// RULE5: Accumulator offset adds signed A, B or D to pointer, changing neither.
// RULE6: Auto-increment uses pointer as address, then adds one or two to it.
// RULE7: Auto-decrement subtracts one or two first, then uses the new value.
// RULE8: Indirect forms read a pointer at the indexed address and use it.
// RULE9: Indirection is offered on all indexed forms except step-by-one modes; this unit also offers none on 5-bit offsets.
// RULE10: Branch loads PC plus signed offset only when condition is true.
// RULE11: Short branch has one offset byte, long branch has two.
// RULE12: Relative addresses wrap modulo 16 bits across the whole space.
// RULE13: PC can be the index base with 8/16-bit offset, also indirect.
// RULE14: Push/pull mask byte selects registers, one bit each, either stack.
// RULE15: Push walks a fixed order; pull walks the opposite order.
// RULE16: Copy/swap source code is postbyte 7..4, destination code is 3..0.
// RULE17: Register codes: D,X,Y,U,S,PC at 0..5; A,B,CC,DP at 8..11.
// RULE18: Copy/swap only between equal widths; other pairs flagged as invalid.
// RULE19: Indirect pointer is two bytes, lower address holds the high half.
`timescale 1ns/1ps
`default_nettype none
`include "amd_map.svh"

module amd_decode (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_start,
	input  wire amd_pkg::amd_kind_type i_kind,
	input  wire logic [7:0]            i_post,
	input  wire logic                  i_long,
	input  wire logic                  i_cond,
	input  wire logic                  i_pull,
	input  wire logic                  i_user,
	input  wire logic [15:0]           i_pc,
	input  wire logic [15:0]           i_x,
	input  wire logic [15:0]           i_y,
	input  wire logic [15:0]           i_u,
	input  wire logic [15:0]           i_s,
	input  wire logic [7:0]            i_a,
	input  wire logic [7:0]            i_b,
	input  wire logic                  i_mem_valid,
	input  wire logic [7:0]            i_mem_data,
	output logic                       o_mem_rd,
	output logic [15:0]                o_mem_addr,
	output logic                       o_busy,
	output logic                       o_done,
	output logic [15:0]                o_ea,
	output logic                       o_illegal,
	output logic                       o_ptr_wr,
	output logic [1:0]                 o_ptr_sel,
	output logic [15:0]                o_ptr_val,
	output logic [15:0]                o_pc_val,
	output logic                       o_taken,
	output logic                       o_stk_valid,
	output logic [2:0]                 o_stk_idx,
	output logic                       o_stk_user,
	output logic                       o_stk_pull,
	output logic [3:0]                 o_xfer_src,
	output logic [3:0]                 o_xfer_dst,
	output logic                       o_xfer_ok
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	// Sign-extend a 5-bit postbyte offset
	function automatic logic [15:0] sx5(input logic [4:0] v);
		return {{11{v[4]}}, v};
	endfunction

	// Sign-extend an 8-bit offset or accumulator
	function automatic logic [15:0] sx8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

	// Pick the pointer register named by postbyte bits 6..5
	function automatic logic [15:0] ptr_pick(input logic [1:0] sel, input logic [15:0] x,
			input logic [15:0] y, input logic [15:0] u, input logic [15:0] s);
		case (sel)
			2'h0: return x;
			2'h1: return y;
			2'h2: return u;
			default: return s;
		endcase
	endfunction

	// Register code check: bit 1 valid, bit 0 wide
	function automatic logic [1:0] code_info(input logic [3:0] c);
		if (c <= `AMD_REG_PC)
			return 2'h3;
		if (c >= `AMD_REG_A && c <= `AMD_REG_DPR)
			return 2'h2;
		return 2'h0;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		amd_pkg::amd_state_type state;
		logic [15:0] fetch, base, off, mem_addr, ea, ptr_val, pc_val;
		logic [7:0]  mask;
		logic [3:0]  src, dst;
		logic [2:0]  cnt, stk_idx;
		logic [1:0]  need, got, ptr_sel;
		logic        ind, pcrel, is_br, cond, wb, mem_rd, done, illegal;
		logic        ptr_wr, taken, stk_valid, user, pull, xfer_ok, busy;
	} amd_regs_type;

	amd_regs_type r_q;
	amd_regs_type r_d;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	// One sequencer serves all request kinds; requests are only taken in idle
	always_comb begin
		logic [15:0] rv;
		logic [15:0] sum;
		logic [2:0]  idx;
		rv = ptr_pick(i_post[6:5], i_x, i_y, i_u, i_s);
		sum = `AMD_RST_WORD;
		idx = r_q.pull ? r_q.cnt : ~r_q.cnt;
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.ptr_wr = 1'b0;
		r_d.taken = 1'b0;
		r_d.stk_valid = 1'b0;
		case (r_q.state)
			amd_pkg::ST_IDLE: begin
				if (i_start) begin
					r_d.fetch = i_pc;
					r_d.pc_val = i_pc;
					r_d.off = `AMD_RST_WORD;
					r_d.need = 2'h0;
					r_d.got = 2'h0;
					r_d.ind = 1'b0;
					r_d.pcrel = 1'b0;
					r_d.is_br = 1'b0;
					r_d.cond = i_cond;
					r_d.wb = 1'b0;
					r_d.illegal = 1'b0;
					r_d.base = rv;
					r_d.ea = rv;
					r_d.ptr_sel = i_post[6:5];
					r_d.ptr_val = rv;
					case (i_kind)
						amd_pkg::KIND_INDEXED: begin
							if (!i_post[`AMD_POST_EXT_BIT]) begin
								r_d.ea = 16'(rv + sx5(i_post[4:0])); // [RULE1] [RULE2] [RULE3]
							end else begin
								r_d.ind = i_post[`AMD_POST_IND_BIT]; // [RULE8]
								case (i_post[3:0])
									`AMD_MODE_INC1, `AMD_MODE_INC2: begin
										// Address first, pointer bumped afterwards
										r_d.wb = 1'b1;
										r_d.ptr_val = 16'(rv + {15'h0000, 1'b1} + {15'h0000, i_post[0]}); // [RULE6]
										r_d.illegal = i_post[`AMD_POST_IND_BIT] && !i_post[0]; // [RULE9]
									end
									`AMD_MODE_DEC1, `AMD_MODE_DEC2: begin
										r_d.wb = 1'b1;
										r_d.ptr_val = 16'(rv - {15'h0000, 1'b1} - {15'h0000, i_post[0]}); // [RULE7]
										r_d.ea = r_d.ptr_val; // [RULE7]
										r_d.illegal = i_post[`AMD_POST_IND_BIT] && !i_post[0]; // [RULE9]
									end
									`AMD_MODE_ZERO: r_d.ea = rv;
									`AMD_MODE_ACCB: r_d.ea = 16'(rv + sx8(i_b)); // [RULE5]
									`AMD_MODE_ACCA: r_d.ea = 16'(rv + sx8(i_a)); // [RULE5]
									`AMD_MODE_ACCD: r_d.ea = 16'(rv + {i_a, i_b}); // [RULE5]
									`AMD_MODE_OFF8: r_d.need = 2'h1; // [RULE4]
									`AMD_MODE_OFF16: r_d.need = 2'h2; // [RULE4]
									`AMD_MODE_PC8, `AMD_MODE_PC16: begin
										r_d.pcrel = 1'b1; // [RULE13]
										r_d.need = i_post[0] ? 2'h2 : 2'h1;
									end
									`AMD_MODE_EXTIND: begin
										// Absolute pointer; only meaningful as indirect
										r_d.base = `AMD_RST_WORD;
										r_d.need = 2'h2;
										r_d.illegal = !i_post[`AMD_POST_IND_BIT];
									end
									default: r_d.illegal = 1'b1;
								endcase
							end
							// An illegal form never starts memory traffic
							if (r_d.illegal) begin
								r_d.ind = 1'b0;
								r_d.need = 2'h0;
								r_d.wb = 1'b0;
							end
							if (r_d.need != 2'h0) begin
								r_d.state = amd_pkg::ST_FETCH;
								r_d.mem_rd = 1'b1;
								r_d.mem_addr = i_pc;
							end else if (r_d.ind) begin
								r_d.state = amd_pkg::ST_IND_HI;
								r_d.mem_rd = 1'b1;
								r_d.mem_addr = r_d.ea; // [RULE8]
							end else begin
								r_d.done = 1'b1;
								r_d.ptr_wr = r_d.wb;
							end
						end
						amd_pkg::KIND_BRANCH: begin
							r_d.need = i_long ? 2'h2 : 2'h1; // [RULE11]
							r_d.pcrel = 1'b1;
							r_d.is_br = 1'b1;
							r_d.state = amd_pkg::ST_FETCH;
							r_d.mem_rd = 1'b1;
							r_d.mem_addr = i_pc;
						end
						amd_pkg::KIND_STACK: begin
							r_d.mask = i_post; // [RULE14]
							r_d.pull = i_pull;
							r_d.user = i_user; // [RULE14]
							r_d.cnt = 3'h0;
							r_d.state = amd_pkg::ST_STK;
						end
						default: begin
							r_d.src = i_post[7:4]; // [RULE16]
							r_d.dst = i_post[3:0]; // [RULE16]
							// Both codes listed and of one width, else refused
							r_d.xfer_ok = (code_info(i_post[7:4]) != 2'h0) && // [RULE17]
								(code_info(i_post[7:4]) == code_info(i_post[3:0])); // [RULE18]
							r_d.done = 1'b1;
						end
					endcase
				end
			end
			amd_pkg::ST_FETCH: begin
				if (i_mem_valid) begin
					r_d.off = {r_q.off[7:0], i_mem_data};
					r_d.got = 2'(r_q.got + 2'h1);
					r_d.fetch = 16'(r_q.fetch + 16'h0001);
					r_d.mem_addr = r_d.fetch;
					r_d.pc_val = r_d.fetch;
					if (r_d.got == r_q.need) begin
						// High offset byte arrives first; sums wrap at 16 bits
						sum = 16'((r_q.pcrel ? r_d.fetch : r_q.base) + // [RULE12] [RULE13]
							(r_q.need == 2'h1 ? sx8(i_mem_data) : r_d.off)); // [RULE4]
						if (r_q.is_br) begin
							r_d.taken = r_q.cond; // [RULE10]
							r_d.pc_val = r_q.cond ? sum : r_d.fetch; // [RULE10]
							r_d.ea = sum;
							r_d.mem_rd = 1'b0;
							r_d.done = 1'b1;
							r_d.state = amd_pkg::ST_IDLE;
						end else if (r_q.ind) begin
							r_d.ea = sum;
							r_d.mem_addr = sum; // [RULE8]
							r_d.state = amd_pkg::ST_IND_HI;
						end else begin
							r_d.ea = sum;
							r_d.mem_rd = 1'b0;
							r_d.done = 1'b1;
							r_d.ptr_wr = r_q.wb;
							r_d.state = amd_pkg::ST_IDLE;
						end
					end
				end
			end
			amd_pkg::ST_IND_HI: begin
				if (i_mem_valid) begin
					r_d.off = {i_mem_data, 8'h00}; // [RULE19]
					r_d.mem_addr = 16'(r_q.mem_addr + 16'h0001); // [RULE19]
					r_d.state = amd_pkg::ST_IND_LO;
				end
			end
			amd_pkg::ST_IND_LO: begin
				if (i_mem_valid) begin
					r_d.ea = {r_q.off[15:8], i_mem_data}; // [RULE8] [RULE19]
					r_d.mem_rd = 1'b0;
					r_d.done = 1'b1;
					r_d.ptr_wr = r_q.wb;
					r_d.state = amd_pkg::ST_IDLE;
				end
			end
			amd_pkg::ST_STK: begin
				// Fixed eight-step walk keeps timing independent of the mask
				r_d.stk_idx = idx; // [RULE15]
				r_d.stk_valid = r_q.mask[idx]; // [RULE14]
				r_d.cnt = 3'(r_q.cnt + 3'h1);
				if (r_q.cnt == `AMD_STK_LAST) begin
					r_d.done = 1'b1;
					r_d.state = amd_pkg::ST_IDLE;
				end
			end
			default: r_d.state = amd_pkg::ST_IDLE;
		endcase
		r_d.busy = (r_d.state != amd_pkg::ST_IDLE); // Kept as a flop like every other output
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	// Every field starts from a constant
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the state register
	assign o_mem_rd    = r_q.mem_rd;
	assign o_mem_addr  = r_q.mem_addr;
	assign o_busy      = r_q.busy;
	assign o_done      = r_q.done;
	assign o_ea        = r_q.ea;
	assign o_illegal   = r_q.illegal;
	assign o_ptr_wr    = r_q.ptr_wr;
	assign o_ptr_sel   = r_q.ptr_sel;
	assign o_ptr_val   = r_q.ptr_val;
	assign o_pc_val    = r_q.pc_val;
	assign o_taken     = r_q.taken;
	assign o_stk_valid = r_q.stk_valid;
	assign o_stk_idx   = r_q.stk_idx;
	assign o_stk_user  = r_q.user;
	assign o_stk_pull  = r_q.pull;
	assign o_xfer_src  = r_q.src;
	assign o_xfer_dst  = r_q.dst;
	assign o_xfer_ok   = r_q.xfer_ok;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	logic idx_go;
	assign idx_go = i_start && !o_busy && i_kind == amd_pkg::KIND_INDEXED;

	a_off5_inline: assert property (idx_go && !i_post[7] |=> o_done && !o_mem_rd && !o_ptr_wr
		&& o_ea == 16'($past(ptr_pick(i_post[6:5], i_x, i_y, i_u, i_s)) + sx5($past(i_post[4:0]))))
		else $error("5-bit offset address wrong"); // [RULE1] [RULE3]
	a_off8_fetch: assert property (idx_go && i_post[7] && i_post[4:0] == 5'h08 |=> o_mem_rd
		&& o_mem_addr == $past(i_pc)) else $error("offset byte not fetched after postbyte"); // [RULE4]
	a_autoinc_step: assert property (idx_go && i_post[7] && i_post[4:0] == 5'h01 |=> o_done
		&& o_ptr_wr && o_ptr_val == 16'(o_ea + 16'h0002)) else $error("increment by two wrong"); // [RULE6]
	a_autodec_step: assert property (idx_go && i_post[7] && i_post[4:0] == 5'h02 |=> o_ptr_wr
		&& o_ea == o_ptr_val && o_ea == 16'($past(ptr_pick(i_post[6:5], i_x, i_y, i_u, i_s)) - 16'h0001))
		else $error("decrement by one wrong"); // [RULE7]
	a_accd_add: assert property (idx_go && i_post[7] && i_post[4:0] == 5'h0b |=> o_done && !o_ptr_wr
		&& !o_mem_rd && o_ea == 16'($past(ptr_pick(i_post[6:5], i_x, i_y, i_u, i_s)) + $past({i_a, i_b})))
		else $error("accumulator offset wrong"); // [RULE5]
	a_ind_refused: assert property (idx_go && i_post[7] && i_post[4] && i_post[3:1] == 3'h0
		&& !i_post[0] |=> o_illegal && o_done) else $error("step-by-one indirect accepted"); // [RULE9]
	a_ptr_byteorder: assert property (r_q.state == amd_pkg::ST_IND_HI && i_mem_valid |=>
		r_q.state == amd_pkg::ST_IND_LO && o_mem_addr == 16'($past(o_mem_addr) + 16'h0001)
		&& o_ea == $past(o_ea)) else $error("indirect pointer byte order wrong"); // [RULE19]
	a_branch_hold: assert property (o_done && r_q.is_br && !o_taken |-> o_pc_val == r_q.fetch)
		else $error("untaken branch moved PC"); // [RULE10]
	a_xfer_width: assert property (i_start && !o_busy && i_kind == amd_pkg::KIND_XFER
		&& i_post == 8'h08 |=> o_done && !o_xfer_ok) else $error("mixed width copy accepted"); // [RULE18]
	a_stk_walk: assert property (r_q.state == amd_pkg::ST_STK && r_q.cnt == 3'h0 |=>
		o_stk_idx == (o_stk_pull ? 3'h0 : 3'h7)) else $error("stack walk start wrong"); // [RULE15]

	c_branch_taken: cover property (o_done && o_taken);
	c_ind_done: cover property (r_q.state == amd_pkg::ST_IND_LO && i_mem_valid);
	c_stk_user: cover property (o_stk_valid && o_stk_user);
	c_xfer_ok: cover property (o_done && o_xfer_ok);

endmodule
`default_nettype wire

// >>> verification/amd_mem_model.sv
// Memory partner for the address-mode decode bench: byte store with a stall option.
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_slow,
	output logic             o_valid,
	output logic [7:0]       o_data
);
	logic       tog_q;
	logic [7:0] last_q;

	// Contents are a hash of the address, so every byte is predictable
	function automatic logic [7:0] byte_at(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Stall phase and last byte shown; off-beat data must not look valid
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tog_q  <= 1'b0;
			last_q <= 8'h00;
		end else begin
			tog_q <= ~tog_q;
			if (o_valid) begin
				last_q <= o_data;
			end
		end
	end

	// Prompt answer, or every other cycle when slow; idle data is the inverse
	assign o_valid = i_rd && (!i_slow || tog_q);
	assign o_data  = o_valid ? byte_at(i_addr) : ~last_q;
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the address-mode decode unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		amd_pkg::amd_kind_type kind;
		logic [7:0]            post;
		logic                  lng;
		logic                  cond;
		logic [15:0]           pc;
	} amd_row_type;
	logic                  clk, rst, start, lng, cond, pull, user, slow, mem_valid;
	amd_pkg::amd_kind_type kind;
	logic [7:0]            post, a, b, mem_data;
	logic [15:0]           pc, x, y, u, s, mem_addr, ea, ptr_val, pc_val, e_ea, e_pc, e_wv;
	logic                  mem_rd, busy, done, illegal, ptr_wr, taken, stk_valid;
	logic                  stk_user, stk_pull, xfer_ok, e_ill, e_wr;
	logic [1:0]            ptr_sel;
	logic [2:0]            stk_idx;
	logic [3:0]            xfer_src, xfer_dst;
	int                    n_fail, comparisons, nbytes, e_nb, nb0;
	amd_row_type           rows[$];
	logic [7:0]            xposts[8] = '{8'h12, 8'h34, 8'h05, 8'h89, 8'hab, 8'h08, 8'h56, 8'hc0};

	amd_decode i_amd_decode (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_start(start), .i_kind(kind), .i_post(post),
		.i_long(lng), .i_cond(cond), .i_pull(pull), .i_user(user), .i_pc(pc), .i_x(x),
		.i_y(y), .i_u(u), .i_s(s), .i_a(a), .i_b(b), .i_mem_valid(mem_valid),
		.i_mem_data(mem_data), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .o_busy(busy),
		.o_done(done), .o_ea(ea), .o_illegal(illegal), .o_ptr_wr(ptr_wr), .o_ptr_sel(ptr_sel),
		.o_ptr_val(ptr_val), .o_pc_val(pc_val), .o_taken(taken), .o_stk_valid(stk_valid),
		.o_stk_idx(stk_idx), .o_stk_user(stk_user), .o_stk_pull(stk_pull),
		.o_xfer_src(xfer_src), .o_xfer_dst(xfer_dst), .o_xfer_ok(xfer_ok)
	);
	amd_mem_model i_amd_mem_model (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_rd(mem_rd), .i_addr(mem_addr),
		.i_slow(slow), .o_valid(mem_valid), .o_data(mem_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reference helpers: memory contents, sign extension, pointer pick, code list
	function automatic logic [7:0] mb(input logic [15:0] q);
		return q[7:0] ^ q[15:8] ^ 8'ha5;
	endfunction
	function automatic logic [15:0] sx8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction
	function automatic logic [15:0] rg(input logic [1:0] k);
		return (k == 2'h0) ? x : (k == 2'h1) ? y : (k == 2'h2) ? u : s;
	endfunction
	function automatic logic lst(input logic [3:0] c);
		return c[3] ? (c[2:0] < 3'h4) : (c[2:0] < 3'h6);
	endfunction

	// Expected outcome of one indexed postbyte
	function automatic void ref_ix(input logic [7:0] p, input logic [15:0] q);
		logic [15:0] r;
		logic [15:0] w;
		r = rg(p[6:5]);
		w = {mb(q), mb(q + 16'h0001)};
		e_ill = 1'b0;
		e_wr = 1'b0;
		e_nb = 0;
		e_pc = q;
		e_ea = r + {{11{p[4]}}, p[4:0]};
		if (p[7]) begin
			case (p[3:0])
			4'h0, 4'h1: begin
				e_ea = r;
				e_wv = r + 16'h0001 + p[0];
				e_wr = 1'b1;
			end
			4'h2, 4'h3: begin
				e_ea = r - 16'h0001 - p[0];
				e_wv = e_ea;
				e_wr = 1'b1;
			end
			4'h4: e_ea = r;
			4'h5: e_ea = r + sx8(b);
			4'h6: e_ea = r + sx8(a);
			4'hb: e_ea = r + {a, b};
			4'h8, 4'hc: begin
				e_pc = q + 16'h0001;
				e_ea = (p[2] ? e_pc : r) + sx8(mb(q));
				e_nb = 1;
			end
			4'h9, 4'hd, 4'hf: begin
				e_pc = q + 16'h0002;
				e_ea = p[1] ? w : (p[2] ? e_pc : r) + w;
				e_nb = 2;
			end
			default: e_ill = 1'b1;
			endcase
			e_ill = e_ill | (p[4] ? (p[3:0] == 4'h0 || p[3:0] == 4'h2) : (p[3:0] == 4'hf));
		end
		if (e_ill) begin
			e_wr = 1'b0;
			e_nb = 0;
		end else if (p[7] & p[4]) begin
			e_ea = {mb(e_ea), mb(e_ea + 16'h0001)};
			e_nb = e_nb + 2;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Running count of bytes accepted by the memory handshake; one writer only
	always @(posedge clk) begin
		if (rst) begin
			nbytes <= 0;
		end else if (mem_rd === 1'b1 && mem_valid === 1'b1) begin
			nbytes <= nbytes + 1;
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Bounded wait for the completion pulse, started just after the taking edge
	task automatic wait_done();
		int n;
		n = 0;
		#1;
		nb0 = nbytes;
		while (done !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 60) chk(16'h0001, 16'h0000);
	endtask

	// One request from a row, then its comparisons
	task automatic run_row(input amd_row_type r);
		logic [15:0] w;
		w = r.lng ? {mb(r.pc), mb(r.pc + 16'h0001)} : sx8(mb(r.pc));
		if (r.kind == amd_pkg::KIND_INDEXED) ref_ix(r.post, r.pc);
		@(posedge clk);
		start <= 1'b1;
		kind  <= r.kind;
		post  <= r.post;
		lng   <= r.lng;
		cond  <= r.cond;
		pc    <= r.pc;
		@(posedge clk);
		start <= 1'b0;
		wait_done();
		case (r.kind)
		amd_pkg::KIND_INDEXED: begin
			chk(illegal, e_ill);
			chk(16'(nbytes - nb0), 16'(e_nb));
			chk(ptr_wr, e_wr);
			if (!e_ill) chk(ea, e_ea);
			if (!e_ill) chk(pc_val, e_pc);
			if (e_wr) chk(ptr_val, e_wv);
			if (e_wr) chk(ptr_sel, r.post[6:5]);
		end
		amd_pkg::KIND_BRANCH: begin
			chk(taken, r.cond);
			chk(pc_val, r.pc + (r.lng ? 16'h0002 : 16'h0001) + (r.cond ? w : 16'h0));
		end
		default: begin
			chk({xfer_src, xfer_dst}, r.post);
			chk(xfer_ok, lst(r.post[7:4]) && lst(r.post[3:0]) && r.post[7] == r.post[3]);
		end
		endcase
	endtask

	// Push or pull of mask 8'h81: two valid steps of the eight, order set by direction
	task automatic run_stack(input logic pl, input logic [2:0] first, input logic [2:0] last);
		logic [2:0] q[$];
		@(posedge clk);
		start <= 1'b1;
		kind  <= amd_pkg::KIND_STACK;
		post  <= 8'h81;
		pull  <= pl;
		user  <= ~pl;
		@(posedge clk);
		start <= 1'b0;
		for (int c = 1; c <= 8; c++) begin
			@(posedge clk);
			#1;
			if (stk_valid === 1'b1) q.push_back(stk_idx);
		end
		chk(done, 1'b1);
		chk({stk_user, stk_pull}, {~pl, pl});
		chk(16'(q.size()), 16'h0002);
		chk({q[0], q[1]}, {first, last});
		$display("test stack pull=%0d done", pl);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	// Main sequence
	initial begin
		{rst, start, lng, cond, pull, user, slow, post, n_fail, comparisons} = '0;
		rst = 1'b1;
		kind = amd_pkg::KIND_XFER;
		{pc, x, y, u, s, a, b} = {16'h4000, 16'h1000, 16'h2ff0, 16'h8000, 16'hfffe, 8'hf0, 8'h85};
		repeat (20) @(posedge clk);
		#1;
		chk({busy, done, mem_rd, ptr_wr}, 16'h0);
		chk(ea, 16'h0);
		$display("test reset done");
		@(posedge clk);
		rst <= 1'b0;
		for (int m = 0; m < 32; m++) begin
			rows.push_back({amd_pkg::KIND_INDEXED, 1'b1, m[3:0] == 4'hf ? 2'h0 : m[2:1],
				m[4], m[3:0], 2'h0, 16'h4000});
		end
		foreach (rows[i]) rows[i].pc = 16'h4000 + 16'h0333 * i[15:0];
		rows.push_back({amd_pkg::KIND_INDEXED, 8'h0f, 2'h0, 16'h4000});
		rows.push_back({amd_pkg::KIND_INDEXED, 8'h70, 2'h0, 16'h4000});
		rows.push_back({amd_pkg::KIND_BRANCH, 8'h00, 2'h1, 16'h4000});
		rows.push_back({amd_pkg::KIND_BRANCH, 8'h00, 2'h0, 16'h4000});
		rows.push_back({amd_pkg::KIND_BRANCH, 8'h00, 2'h3, 16'hfffe});
		rows.push_back({amd_pkg::KIND_BRANCH, 8'h00, 2'h2, 16'h4000});
		rows.push_back({amd_pkg::KIND_BRANCH, 8'h00, 2'h1, 16'hffff});
		foreach (xposts[i]) begin
			rows.push_back({amd_pkg::KIND_XFER, xposts[i], 2'h0, 16'h0});
		end
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			slow <= p[0];
			if (p == 1) {x, y, u, s, a, b} <= {16'hff80, 16'h0010, 16'h7fff, 16'h0001, 8'h7f, 8'h01};
			#1;
			foreach (rows[i]) run_row(rows[i]);
			$display("test rows pass %0d done", p);
		end
		run_stack(1'b0, 3'h7, 3'h0);
		run_stack(1'b1, 3'h0, 3'h7);
		// Back-to-back requests, the second given while the first completes
		@(posedge clk);
		start <= 1'b1;
		kind  <= amd_pkg::KIND_XFER;
		post  <= 8'h12;
		@(posedge clk);
		post  <= 8'h89;
		#1;
		chk({done, 3'h0, xfer_src}, 8'h81);
		@(posedge clk);
		kind  <= amd_pkg::KIND_INDEXED;
		post  <= 8'h89;
		pc    <= 16'h4000;
		#1;
		chk({done, 3'h0, xfer_src}, 8'h88);
		// Start held high while busy must be ignored until completion
		ref_ix(8'h89, 16'h4000);
		@(posedge clk);
		kind  <= amd_pkg::KIND_XFER;
		post  <= 8'hab;
		wait_done();
		chk(ea, e_ea);
		chk(xfer_src, 4'h8);
		@(posedge clk);
		start <= 1'b0;
		#1;
		chk({xfer_src, 3'h0, xfer_ok}, 8'ha1);
		$display("test back to back done");
		// Reset in the middle of an indirect 16-bit offset fetch
		@(posedge clk);
		start <= 1'b1;
		kind  <= amd_pkg::KIND_INDEXED;
		post  <= 8'hb9;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		rst <= 1'b1;
		#1;
		chk({busy, done, mem_rd}, 16'h0);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		run_row({amd_pkg::KIND_INDEXED, 8'hb9, 2'h0, 16'h4000});
		$display("test mid-run reset done");
		stop_test();
	end
endmodule
`default_nettype wire
